// File: pmsc_regs.sv
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Overview of operation
// - host command selects exactly one of four operating modes
// - standby on command, wake on command, current state reported
// - host reset command performs a software reset of the block
// - video mode source: rgb, nine-pattern generator, flash, solid colour
// - pattern modes show depths 1 to 8 from flash, rgb or memory
// - on-the-fly mode accepts pattern bitmaps over usb or i2c
// - control commands arrive through the usb hid class endpoint
// - memory test at power-up sets a flag when it passes
// - incompatibility or mirror link failure sets a flag
// - two-controller setup flags secondary controller present and ready
// - init-complete flag only after all power-up routines pass
// - overlapping bias or reset on one block sets an error flag
// - any forced buffer swap sets a flag, short back porch in video mode included
// - streamed pattern mode: vsync misalignment also sets swap flag
// - aborted pattern sequence sets a flag
// - pattern sequence error sets a flag
// - parked flag holds while mirrors are parked
// - running flag holds while the sequencer runs
// - video flag holds while video is processed normally
// - lock flag follows external rgb lock, drops at once on loss
// - switch to streamed pattern mode refused without lock
module pmsc_regs #(
  parameter int MEM_AW = 8,
  parameter int MEM_DW = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pmsc_pkg::pmsc_evt_t evt,
  input wire pmsc_pkg::pmsc_lvl_t lvl,
  input wire logic two_ctrl,
  input wire logic i2c_wr_valid,
  input wire logic [MEM_DW-1:0] i2c_wr_data,
  output logic i2c_wr_ack,
  input wire logic [MEM_AW-1:0] seq_rd_addr,
  output logic [MEM_DW-1:0] seq_rd_data,
  output pmsc_pkg::pmsc_ctrl_t ctrl,
  output logic soft_rst
);

  if (MEM_AW < 2 || MEM_AW > 16 || MEM_DW < 8 || MEM_DW > 32) begin : g_chk
    $error("pmsc_regs: memory shape not supported");
  end

  typedef enum {MT_WR, MT_RD, MT_CHK, MT_DONE} pmsc_mt_t;

  localparam logic [MEM_AW-1:0] LAST_ADDR = '1;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a[7:2] == o[7:2]);
  endfunction

  pmsc_pkg::pmsc_ctrl_t ctrl_q;
  pmsc_pkg::pmsc_ctrl_t wr_ctrl;
  pmsc_mt_t mt_q;
  logic [MEM_DW-1:0] mem [2**MEM_AW];
  logic [MEM_DW-1:0] rd_q;
  logic [MEM_AW-1:0] mt_addr_q;
  logic [MEM_AW-1:0] chk_addr_q;
  logic [MEM_AW-1:0] load_ptr_q;
  logic mt_pass_q;
  logic mt_fail_q;
  logic init_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic soft_rst_q;
  logic i2c_ack_q;
  logic acc;
  logic wr_ctrl_go;
  logic wr_clr_go;
  logic wr_load_go;
  logic swreq;
  logic vpat_ok;
  logic ctrl_ok;
  logic i2c_take;
  logic [5:0] evt_set;
  logic [5:0] sticky_q;
  logic [5:0] clr_bits;
  logic [7:0] lvl_q;
  logic refused_q;
  logic [MEM_DW-1:0] mt_pat;
  logic [MEM_DW-1:0] mt_exp;

  // apb handshake: pready comes in the first access cycle, no wait state
  assign acc = psel && penable && pready_q;
  assign wr_ctrl_go = acc && pwrite && hit(paddr, pmsc_pkg::ADDR_CTRL);
  assign wr_clr_go = acc && pwrite && hit(paddr, pmsc_pkg::ADDR_CLR);
  assign wr_load_go = acc && pwrite && hit(paddr, pmsc_pkg::ADDR_LOAD);
  assign swreq = wr_ctrl_go && pwdata[pmsc_pkg::SWRST_BIT];
  assign wr_ctrl = pmsc_pkg::pmsc_ctrl_t'(pwdata[pmsc_pkg::CTRL_W-1:0]);

  // streamed pattern mode needs a live external lock
  assign vpat_ok = (wr_ctrl.mode != pmsc_pkg::MODE_VPAT) || lvl.locked;
  // a bad field value refuses the whole control write
  assign ctrl_ok = vpat_ok &&
                   (wr_ctrl.tpat <= pmsc_pkg::TPAT_LAST) &&
                   (wr_ctrl.psrc != pmsc_pkg::PSRC_BAD);

  // i2c loads yield to an apb load in the same cycle
  assign i2c_take = i2c_wr_valid && !wr_load_go && !i2c_ack_q &&
                    (ctrl_q.mode == pmsc_pkg::MODE_OTF) && (mt_q == MT_DONE);

  // ready rises one edge after setup and drops after the access edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
    end else if (ce) begin
      pready_q <= psel && !pready_q;
    end
  end

  // control register; software reset returns it to defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= pmsc_pkg::CTRL_RST;
    end else if (ce) begin
      if (swreq) begin
        ctrl_q <= pmsc_pkg::CTRL_RST;
      end else if (wr_ctrl_go && ctrl_ok) begin
        ctrl_q <= wr_ctrl;
      end
    end
  end

  // refusal flag; sticky until cleared like the event flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refused_q <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl_go && !swreq && !ctrl_ok) begin
        refused_q <= 1'b1;
      end else if (swreq || (wr_clr_go && pwdata[pmsc_pkg::ST_REFUSED])) begin
        refused_q <= 1'b0;
      end
    end
  end

  // reset pulse for the rest of the controller, one cycle long
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_rst_q <= 1'b0;
    end else if (ce) begin
      soft_rst_q <= swreq;
    end
  end

  // event capture; set beats a clear landing in the same cycle
  assign evt_set = {
    evt.rst_wave_err,
    evt.swap_forced ||
      (evt.vbp_short && ctrl_q.mode == pmsc_pkg::MODE_VIDEO) ||
      (evt.vsync_mismatch && ctrl_q.mode == pmsc_pkg::MODE_VPAT),
    evt.seq_abort,
    evt.seq_err,
    lvl.incompat || lvl.link_fail,
    1'b0
  };
  assign clr_bits = wr_clr_go ? {pwdata[pmsc_pkg::ST_RSTWAVE],
                                 pwdata[pmsc_pkg::ST_SWAP],
                                 pwdata[pmsc_pkg::ST_ABORT],
                                 pwdata[pmsc_pkg::ST_SEQERR],
                                 pwdata[pmsc_pkg::ST_INCOMPAT], 1'b0}
                              : 6'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sticky_q <= 6'h00;
    end else if (ce) begin
      if (swreq) begin
        sticky_q <= evt_set;
      end else begin
        sticky_q <= evt_set | (sticky_q & ~clr_bits);
      end
    end
  end

  // level flags are resampled every cycle, so loss shows next edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= 8'h00;
    end else if (ce) begin
      lvl_q <= {two_ctrl && lvl.slave_rdy,
                lvl.parked,
                lvl.seq_run,
                lvl.video_run,
                lvl.locked,
                1'b0, 1'b0, 1'b0};
    end
  end

  // power-up walk: write a seeded pattern, read it back, compare
  assign mt_pat = pmsc_pkg::MT_SEED[MEM_DW-1:0] ^ MEM_DW'(mt_addr_q);
  assign mt_exp = pmsc_pkg::MT_SEED[MEM_DW-1:0] ^ MEM_DW'(chk_addr_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mt_q <= MT_WR;
      mt_addr_q <= '0;
      chk_addr_q <= '0;
      mt_pass_q <= 1'b0;
      mt_fail_q <= 1'b0;
    end else if (ce) begin
      case (mt_q)
        MT_WR: begin
          mt_addr_q <= mt_addr_q + 1'b1;
          if (mt_addr_q == LAST_ADDR) begin
            mt_q <= MT_RD;
          end
        end
        MT_RD: begin
          chk_addr_q <= mt_addr_q;
          mt_addr_q <= mt_addr_q + 1'b1;
          mt_q <= MT_CHK;
        end
        MT_CHK: begin
          if (rd_q != mt_exp) begin
            mt_fail_q <= 1'b1;
          end
          if (chk_addr_q == LAST_ADDR) begin
            mt_q <= MT_DONE;
            mt_pass_q <= !mt_fail_q && (rd_q == mt_exp);
          end else begin
            chk_addr_q <= mt_addr_q;
            mt_addr_q <= mt_addr_q + 1'b1;
          end
        end
        default: begin
          mt_q <= MT_DONE;
        end
      endcase
    end
  end

  // init done needs the memory test and the firmware routines
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_q <= 1'b0;
    end else if (ce) begin
      init_q <= mt_pass_q && lvl.fw_init_ok;
    end
  end

  // pattern memory: test walk, then host loads in on-the-fly mode
  always_ff @(posedge clk) begin
    if (ce) begin
      if (mt_q == MT_WR) begin
        mem[mt_addr_q] <= mt_pat;
      end else if (mt_q == MT_DONE && wr_load_go &&
                   ctrl_q.mode == pmsc_pkg::MODE_OTF) begin
        mem[load_ptr_q] <= pwdata[MEM_DW-1:0];
      end else if (i2c_take) begin
        mem[load_ptr_q] <= i2c_wr_data;
      end
    end
  end

  // one read port shared by the test walk and the sequencer
  always_ff @(posedge clk) begin
    if (ce) begin
      rd_q <= mem[(mt_q == MT_DONE) ? seq_rd_addr : mt_addr_q];
    end
  end

  // load pointer advances on each accepted word, rewinds on reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_ptr_q <= '0;
      i2c_ack_q <= 1'b0;
    end else if (ce) begin
      i2c_ack_q <= i2c_take;
      if (swreq || (wr_ctrl_go && ctrl_ok)) begin
        load_ptr_q <= '0;
      end else if ((mt_q == MT_DONE && wr_load_go &&
                    ctrl_q.mode == pmsc_pkg::MODE_OTF) || i2c_take) begin
        load_ptr_q <= load_ptr_q + 1'b1;
      end
    end
  end

  // read mux, registered so prdata comes from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      if (psel && !pready_q) begin
        if (hit(paddr, pmsc_pkg::ADDR_CTRL)) begin
          prdata_q <= 32'(ctrl_q);
        end else if (hit(paddr, pmsc_pkg::ADDR_STAT)) begin
          prdata_q[pmsc_pkg::ST_MEMTEST] <= mt_pass_q;
          prdata_q[pmsc_pkg::ST_INCOMPAT] <= sticky_q[1];
          prdata_q[pmsc_pkg::ST_SLAVE] <= lvl_q[7];
          prdata_q[pmsc_pkg::ST_INIT] <= init_q;
          prdata_q[pmsc_pkg::ST_RSTWAVE] <= sticky_q[5];
          prdata_q[pmsc_pkg::ST_SWAP] <= sticky_q[4];
          prdata_q[pmsc_pkg::ST_ABORT] <= sticky_q[3];
          prdata_q[pmsc_pkg::ST_SEQERR] <= sticky_q[2];
          prdata_q[pmsc_pkg::ST_PARKED] <= lvl_q[6];
          prdata_q[pmsc_pkg::ST_SEQRUN] <= lvl_q[5];
          prdata_q[pmsc_pkg::ST_VIDRUN] <= lvl_q[4];
          prdata_q[pmsc_pkg::ST_LOCKED] <= lvl_q[3];
          prdata_q[pmsc_pkg::ST_STBY] <= ctrl_q.stby;
          prdata_q[pmsc_pkg::ST_REFUSED] <= refused_q;
          prdata_q[pmsc_pkg::ST_MODE+1:pmsc_pkg::ST_MODE] <= ctrl_q.mode;
        end else if (hit(paddr, pmsc_pkg::ADDR_LOAD)) begin
          prdata_q <= 32'(load_ptr_q);
        end else if (!hit(paddr, pmsc_pkg::ADDR_CLR)) begin
          pslverr_q <= 1'b1; // unmapped offset
        end
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q; // only ever set together with pready_q
  assign ctrl = ctrl_q;
  assign soft_rst = soft_rst_q;
  assign i2c_wr_ack = i2c_ack_q;
  assign seq_rd_data = rd_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_vpat_refused;
    ce && wr_ctrl_go && !swreq && wr_ctrl.mode == pmsc_pkg::MODE_VPAT &&
      !lvl.locked |=> ctrl_q.mode == $past(ctrl_q.mode) && refused_q;
  endproperty
  a_vpat_refused: assert property (p_vpat_refused)
    else $error("streamed pattern mode taken without lock");

  property p_stby;
    ce && wr_ctrl_go && !swreq && ctrl_ok |=> ctrl_q.stby == $past(pwdata[2]);
  endproperty
  a_stby: assert property (p_stby)
    else $error("standby bit did not follow the command");

  property p_swrst;
    ce && swreq |=> soft_rst && ctrl_q == pmsc_pkg::CTRL_RST && load_ptr_q == 0;
  endproperty
  a_swrst: assert property (p_swrst)
    else $error("software reset did not restore defaults");

  property p_lock_drop;
    ce && !lvl.locked |=> !lvl_q[3];
  endproperty
  a_lock_drop: assert property (p_lock_drop)
    else $error("lock flag held after loss of lock");

  property p_vsync_swap;
    ce && evt.vsync_mismatch && ctrl_q.mode == pmsc_pkg::MODE_VPAT
      |=> sticky_q[4];
  endproperty
  a_vsync_swap: assert property (p_vsync_swap)
    else $error("vsync mismatch did not set swap flag");

  property p_abort_hold;
    ce && evt.seq_abort ##1 (ce && !wr_clr_go && !swreq)[*2] |-> sticky_q[3];
  endproperty
  a_abort_hold: assert property (p_abort_hold)
    else $error("abort flag lost without a clear");

  property p_init_order;
    init_q |-> mt_pass_q && mt_q == MT_DONE;
  endproperty
  a_init_order: assert property (p_init_order)
    else $error("init complete before memory test passed");

  property p_tpat;
    ctrl_q.tpat <= pmsc_pkg::TPAT_LAST && ctrl_q.psrc != pmsc_pkg::PSRC_BAD;
  endproperty
  a_tpat: assert property (p_tpat)
    else $error("illegal test pattern or pattern source held");

  property p_otf_only;
    ce && $changed(load_ptr_q) && !$past(swreq) && !$past(wr_ctrl_go)
      |-> ctrl_q.mode == pmsc_pkg::MODE_OTF || $past(ctrl_q.mode) ==
          pmsc_pkg::MODE_OTF;
  endproperty
  a_otf_only: assert property (p_otf_only)
    else $error("pattern load accepted outside on-the-fly mode");

  c_memtest: cover property (mt_q == MT_DONE && mt_pass_q);
  c_refuse: cover property (refused_q);
  c_i2c: cover property (i2c_wr_ack);
  c_vpat: cover property (ctrl_q.mode == pmsc_pkg::MODE_VPAT);

endmodule

// File: pmsc_pkg.sv
package pmsc_pkg;

  // apb byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_CLR = 8'h08;
  localparam logic [7:0] ADDR_LOAD = 8'h0c;

  typedef enum logic [1:0] {
    MODE_VIDEO, MODE_STORED, MODE_VPAT, MODE_OTF
  } pmsc_mode_t;

  typedef enum logic [1:0] {
    VSRC_RGB, VSRC_TPG, VSRC_FLASH, VSRC_SOLID
  } pmsc_vsrc_t;

  // pattern source; code 3 is not a source and is refused
  localparam logic [1:0] PSRC_FLASH = 2'h0;
  localparam logic [1:0] PSRC_RGB = 2'h1;
  localparam logic [1:0] PSRC_MEM = 2'h2;
  localparam logic [1:0] PSRC_BAD = 2'h3;

  // control word, bit 0 upward: mode, standby, vsrc, tpat, depth-1, psrc
  typedef struct packed {
    logic [1:0] psrc;
    logic [2:0] depth_m1;
    logic [3:0] tpat;
    pmsc_vsrc_t vsrc;
    logic stby;
    pmsc_mode_t mode;
  } pmsc_ctrl_t;

  localparam int CTRL_W = 14;
  localparam pmsc_ctrl_t CTRL_RST = '0;
  localparam logic [3:0] TPAT_LAST = 4'h8;
  localparam int SWRST_BIT = 31;

  // status word bit positions
  localparam int ST_MEMTEST = 0;
  localparam int ST_INCOMPAT = 1;
  localparam int ST_SLAVE = 2;
  localparam int ST_INIT = 3;
  localparam int ST_RSTWAVE = 4;
  localparam int ST_SWAP = 5;
  localparam int ST_ABORT = 6;
  localparam int ST_SEQERR = 7;
  localparam int ST_PARKED = 8;
  localparam int ST_SEQRUN = 9;
  localparam int ST_VIDRUN = 10;
  localparam int ST_LOCKED = 11;
  localparam int ST_STBY = 12;
  localparam int ST_REFUSED = 13;
  localparam int ST_MODE = 16;

  // one-cycle event strobes from the display pipeline
  typedef struct packed {
    logic rst_wave_err;
    logic swap_forced;
    logic vbp_short;
    logic vsync_mismatch;
    logic seq_abort;
    logic seq_err;
  } pmsc_evt_t;

  // level conditions from the display pipeline
  typedef struct packed {
    logic incompat;
    logic link_fail;
    logic slave_rdy;
    logic parked;
    logic seq_run;
    logic video_run;
    logic locked;
    logic fw_init_ok;
  } pmsc_lvl_t;

  localparam logic [31:0] MT_SEED = 32'h5a5a_0000;

endpackage

// File: pmsc_i2c_host.sv
`timescale 1ns/10ps
// host-side i2c pattern loader: offers one word and holds it until ack
module pmsc_i2c_host (
  input wire logic clk,
  input wire logic go,
  input wire logic [31:0] word,
  output logic i2c_wr_valid,
  output logic [31:0] i2c_wr_data,
  input wire logic i2c_wr_ack
);
  initial begin
    i2c_wr_valid = 1'b0;
    i2c_wr_data = 32'h0;
  end

  // released data is inverted so a late sample never matches by luck
  always @(posedge clk) begin
    if (go) begin
      i2c_wr_valid <= 1'b1;
      i2c_wr_data <= word;
    end else if (i2c_wr_ack) begin
      i2c_wr_valid <= 1'b0;
      i2c_wr_data <= ~i2c_wr_data;
    end
  end
endmodule

// File: projector_mode_status_control_tb.sv
`timescale 1ns/10ps
module projector_mode_status_control_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] evt_v = 6'h00;
  logic [7:0] lvl_v = 8'h01;
  logic two_ctrl = 1'b0;
  logic go = 1'b0;
  logic [31:0] word = 32'h0;
  logic i2c_valid;
  logic [31:0] i2c_data;
  logic i2c_ack;
  logic [3:0] rd_addr = 4'h0;
  logic [31:0] rd_data;
  pmsc_pkg::pmsc_ctrl_t ctrl;
  logic soft_rst;
  int fail_count = 0;
  int cmp_count = 0;
  logic [31:0] r;
  logic e;
  int n;
  // control writes and the control word expected after each
  localparam logic [31:0] WV[12] = '{32'h4, 32'h0, 32'h8, 32'h10, 32'h18,
    32'h100, 32'h120, 32'he01, 32'h1e01, 32'h2e01, 32'h3e01, 32'h1};
  localparam logic [31:0] XV[12] = '{32'h4, 32'h0, 32'h8, 32'h10, 32'h18,
    32'h100, 32'h100, 32'he01, 32'h1e01, 32'h2e01, 32'h2e01, 32'h1};
  localparam int EV_IDX[5] = '{5, 4, 3, 1, 0};
  localparam int EV_BIT[5] = '{4, 5, 5, 6, 7};
  localparam int LV_IDX[7] = '{7, 6, 5, 4, 3, 2, 1};
  localparam int LV_BIT[7] = '{1, 1, 2, 8, 9, 10, 11};

  pmsc_regs #(.MEM_AW(4)) i_dut (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .evt(pmsc_pkg::pmsc_evt_t'(evt_v)),
    .lvl(pmsc_pkg::pmsc_lvl_t'(lvl_v)),
    .two_ctrl(two_ctrl),
    .i2c_wr_valid(i2c_valid),
    .i2c_wr_data(i2c_data),
    .i2c_wr_ack(i2c_ack),
    .seq_rd_addr(rd_addr),
    .seq_rd_data(rd_data),
    .ctrl(ctrl),
    .soft_rst(soft_rst)
  );

  pmsc_i2c_host i_host (
    .clk(clk),
    .go(go),
    .word(word),
    .i2c_wr_valid(i2c_valid),
    .i2c_wr_data(i2c_data),
    .i2c_wr_ack(i2c_ack)
  );

  // 250 mhz
  always #2 clk = ~clk;

  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; the wait is bounded, not assumed
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      fail_count++;
      print_verdict();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic st(input int b, input logic x);
    apb(1'b0, pmsc_pkg::ADDR_STAT, 32'h0);
    chk({31'h0, r[b]}, {31'h0, x});
  endtask

  // one idle edge lets the control word land before it is compared
  task automatic wctrl(input logic [31:0] v);
    apb(1'b1, pmsc_pkg::ADDR_CTRL, v);
    idle(1);
  endtask

  task automatic clr(input logic [31:0] m);
    apb(1'b1, pmsc_pkg::ADDR_CLR, m);
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    evt_v <= 6'h01 << i;
    @(posedge clk);
    evt_v <= 6'h00;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, pmsc_pkg::ADDR_CTRL, 32'h0);
    chk(r, 32'h0);
    st(pmsc_pkg::ST_INIT, 1'b0);
    for (n = 0; n < 40; n++) begin
      apb(1'b0, pmsc_pkg::ADDR_STAT, 32'h0);
      if (r[pmsc_pkg::ST_MEMTEST] === 1'b1) break;
    end
    chk({31'h0, r[pmsc_pkg::ST_MEMTEST]}, 32'h1);
    st(pmsc_pkg::ST_INIT, 1'b1);
    // every mode with lock present, then streamed mode without lock
    lvl_v <= 8'h03;
    for (n = 0; n < 4; n++) begin
      wctrl(n);
      chk({18'h0, ctrl}, n);
      apb(1'b0, pmsc_pkg::ADDR_STAT, 32'h0);
      chk({30'h0, r[17:16]}, n);
    end
    lvl_v <= 8'h01;
    wctrl(32'h1);
    st(pmsc_pkg::ST_LOCKED, 1'b0);
    wctrl(32'h2);
    chk({18'h0, ctrl}, 32'h1);
    st(pmsc_pkg::ST_REFUSED, 1'b1);
    clr(32'h2000);
    st(pmsc_pkg::ST_REFUSED, 1'b0);
    // standby, sources, test patterns, depths and pattern sources
    for (n = 0; n < 12; n++) begin
      wctrl(WV[n]);
      chk({18'h0, ctrl}, XV[n]);
      st(pmsc_pkg::ST_STBY, XV[n][2]);
    end
    // sticky event flags, read twice before trusting them
    wctrl(32'h0);
    for (n = 0; n < 5; n++) begin
      pulse(EV_IDX[n]);
      st(EV_BIT[n], 1'b1);
      st(EV_BIT[n], 1'b1);
      clr(32'hf0);
      st(EV_BIT[n], 1'b0);
    end
    pulse(2);
    st(pmsc_pkg::ST_SWAP, 1'b0);
    lvl_v <= 8'h03;
    idle(2);
    wctrl(32'h2);
    pulse(2);
    st(pmsc_pkg::ST_SWAP, 1'b1);
    clr(32'h20);
    pulse(3);
    st(pmsc_pkg::ST_SWAP, 1'b0);
    // level flags follow their conditions
    two_ctrl <= 1'b1;
    for (n = 0; n < 7; n++) begin
      lvl_v <= 8'h01 | (8'h01 << LV_IDX[n]);
      idle(2);
      st(LV_BIT[n], 1'b1);
      lvl_v <= 8'h01;
      idle(2);
      clr(32'h2);
      st(LV_BIT[n], 1'b0);
    end
    two_ctrl <= 1'b0;
    lvl_v <= 8'h21;
    idle(2);
    st(pmsc_pkg::ST_SLAVE, 1'b0);
    // on-the-fly loading over both links
    wctrl(32'h3);
    apb(1'b1, pmsc_pkg::ADDR_LOAD, 32'hc0de_0001);
    @(posedge clk);
    go <= 1'b1;
    word <= 32'h1234_abcd;
    @(posedge clk);
    go <= 1'b0;
    for (n = 0; n < 10; n++) begin
      @(posedge clk);
      if (i2c_ack === 1'b1) break;
    end
    chk({31'h0, i2c_ack}, 32'h1);
    apb(1'b0, pmsc_pkg::ADDR_LOAD, 32'h0);
    chk(r, 32'h2);
    rd_addr <= 4'h0;
    idle(2);
    chk(rd_data, 32'hc0de_0001);
    rd_addr <= 4'h1;
    idle(2);
    chk(rd_data, 32'h1234_abcd);
    // software reset clears control, sticky flags and load pointer
    pulse(0);
    apb(1'b1, pmsc_pkg::ADDR_CTRL, 32'h8000_0000);
    n = 0;
    repeat (4) begin
      @(negedge clk);
      if (soft_rst === 1'b1) n++;
    end
    chk(n, 32'h1);
    chk({18'h0, ctrl}, 32'h0);
    st(pmsc_pkg::ST_SEQERR, 1'b0);
    apb(1'b0, pmsc_pkg::ADDR_LOAD, 32'h0);
    chk(r, 32'h0);
    // a low clock enable freezes the flags, so an event is not seen
    ce <= 1'b0;
    pulse(5);
    ce <= 1'b1;
    st(pmsc_pkg::ST_RSTWAVE, 1'b0);
    // unmapped offset answers with an error
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, e}, 32'h1);
    print_verdict();
  end
endmodule
